// File: src/lcdc_defs.vh
`ifndef LCDC_DEFS_VH
`define LCDC_DEFS_VH
// Command codes.
`define LCDC_CMD_DISP_OFF 8'h58
`define LCDC_CMD_DISP_ON 8'h59
`define LCDC_CMD_CSR_LOAD 8'h46
`define LCDC_CMD_CSR_SHAPE 8'h5D
`define LCDC_CMD_DIR_BASE 6'h13
`define LCDC_CMD_MEM_STORE 8'h42
// Register offsets.
`define LCDC_REG_DISP_EN 8'h09
`define LCDC_REG_DISP_ATTR 8'h0A
`define LCDC_REG_CSR_WIDTH 8'h15
`define LCDC_REG_CSR_HSHAPE 8'h16
`define LCDC_REG_CURSOR_DIRECTION_CMD 8'h17
`define LCDC_REG_CSR_LO 8'h1C
`define LCDC_REG_CSR_HI 8'h1D
// Field positions.
`define LCDC_DISP_EN_BIT 0
`define LCDC_SHAPE_BLOCK_BIT 7
// Direction codes.
`define LCDC_DIR_RIGHT 2'h0
`define LCDC_DIR_LEFT 2'h1
`define LCDC_DIR_UP 2'h2
`define LCDC_DIR_DOWN 2'h3
// Reset values.
`define LCDC_RST_BYTE 8'h00
`define LCDC_RST_LINE_WIDTH 16'h0080
`endif

// File: src/lcdc_mem.v
`timescale 1ns/1ps
`default_nettype none
// Display memory with a registered read port.
module lcdc_mem #(
  parameter AW = 15,
  parameter DEPTH = 32768
) (
  // Clock
  input wire clk_in,
  // Write port
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  // Read port
  input wire [AW-1:0] rd_addr_in,
  output reg [7:0] rd_data_out
);
  reg [7:0] mem_q [0:DEPTH-1];

  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule
`default_nettype wire

// File: src/lcdc_cmd_decoder.v
// Operation
// - Command 58h clears and 59h sets display enable bit 0, each then takes one attribute byte.
// - Bits 1-0 of that attribute byte are the cursor flash rate, 56h meaning flash at 2 Hz.
// - Bits 3-2, 5-4 and 7-6 of that byte hold the attributes of blocks one, two/four and three.
// - Command 46h loads the cursor address from two bytes, low byte first then high byte.
// - Command 5Dh stores bits 3-0 of its first byte as cursor width minus one.
// - The second 5Dh byte holds cursor height minus one in bits 3-0 and a block cursor flag in bit 7.
// - Codes 4Ch to 4Fh set the shift direction from their low two bits, 4Ch right and 4Fh down.
// - Command 42h writes each following byte at the cursor and then moves the cursor.
// - When the direction is down, the cursor advances by the virtual line width instead of one.
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_defs.vh"
module lcdc_cmd_decoder #(
  parameter AW = 15,
  parameter DEPTH = 32768
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Host byte stream
  input wire wr_in,
  input wire cmd_in,
  input wire [7:0] data_in,
  // Virtual screen width in addresses
  input wire [15:0] line_width_in,
  // Register read port
  input wire [7:0] reg_addr_in,
  output reg [7:0] reg_data_out,
  // Display memory read port
  input wire [AW-1:0] mem_rd_addr_in,
  output wire [7:0] mem_rd_data_out,
  // Attribute outputs
  output reg display_enable_out,
  output reg [1:0] cursor_flash_rate_out,
  output reg [5:0] screen_block_attribute_out,
  output reg [3:0] cursor_width_out,
  output reg [3:0] cursor_height_out,
  output reg cursor_shape_select_out,
  output reg [1:0] cursor_direction_out,
  output reg [15:0] cursor_addr_out
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_DISP = 5'b00010;
  localparam ST_CSR = 5'b00100;
  localparam ST_SHAPE = 5'b01000;
  localparam ST_MEM = 5'b10000;

  reg [4:0] state_q;
  reg mem_mode_q;
  reg param_idx_q;
  reg [7:0] disp_en_q;
  reg [7:0] disp_attr_q;
  reg [7:0] width_q;
  reg [7:0] hshape_q;
  reg [7:0] dir_q;
  reg [15:0] csr_q;
  reg mem_we;
  reg [15:0] step;

  // Cursor step for the current shift direction.
  function [15:0] csr_step;
    input [1:0] dir;
    input [15:0] lw;
    begin
      case (dir)
        `LCDC_DIR_RIGHT: csr_step = 16'h0001;
        `LCDC_DIR_LEFT: csr_step = 16'hFFFF;
        `LCDC_DIR_UP: csr_step = (~lw) + 16'h0001;
        default: csr_step = lw;
      endcase
    end
  endfunction

  always @* begin
    mem_we = wr_in && !cmd_in && mem_mode_q;
    step = csr_step(dir_q[1:0], line_width_in);
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      mem_mode_q <= 1'b0;
      param_idx_q <= 1'b0;
      disp_en_q <= `LCDC_RST_BYTE;
      disp_attr_q <= `LCDC_RST_BYTE;
      width_q <= `LCDC_RST_BYTE;
      hshape_q <= `LCDC_RST_BYTE;
      dir_q <= `LCDC_RST_BYTE;
      csr_q <= 16'h0000;
    end else if (wr_in && cmd_in) begin
      // A new command always ends the previous parameter run.
      param_idx_q <= 1'b0;
      mem_mode_q <= 1'b0;
      state_q <= ST_IDLE;
      if (data_in == `LCDC_CMD_DISP_OFF) begin
        disp_en_q[`LCDC_DISP_EN_BIT] <= 1'b0;
        state_q <= ST_DISP;
      end else if (data_in == `LCDC_CMD_DISP_ON) begin
        disp_en_q[`LCDC_DISP_EN_BIT] <= 1'b1;
        state_q <= ST_DISP;
      end else if (data_in == `LCDC_CMD_CSR_LOAD) begin
        state_q <= ST_CSR;
      end else if (data_in == `LCDC_CMD_CSR_SHAPE) begin
        state_q <= ST_SHAPE;
      end else if (data_in[7:2] == `LCDC_CMD_DIR_BASE) begin
        dir_q <= {6'h00, data_in[1:0]};
      end else if (data_in == `LCDC_CMD_MEM_STORE) begin
        mem_mode_q <= 1'b1;
        state_q <= ST_MEM;
      end
    end else if (wr_in) begin
      case (state_q)
        ST_DISP: begin
          // Whole byte kept: flash rate in 1-0, block fields above.
          disp_attr_q <= data_in;
          state_q <= ST_IDLE;
        end
        ST_CSR: begin
          if (!param_idx_q) begin
            csr_q[7:0] <= data_in;
            param_idx_q <= 1'b1;
          end else begin
            csr_q[15:8] <= data_in;
            param_idx_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_SHAPE: begin
          if (!param_idx_q) begin
            width_q <= {4'h0, data_in[3:0]};
            param_idx_q <= 1'b1;
          end else begin
            hshape_q <= {data_in[7], 3'h0, data_in[3:0]};
            param_idx_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_MEM: begin
          if (mem_mode_q) begin
            csr_q <= csr_q + step;
          end
        end
        default: begin
          // Parameters with no open command are dropped.
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      reg_data_out <= 8'h00;
      display_enable_out <= 1'b0;
      cursor_flash_rate_out <= 2'h0;
      screen_block_attribute_out <= 6'h00;
      cursor_width_out <= 4'h0;
      cursor_height_out <= 4'h0;
      cursor_shape_select_out <= 1'b0;
      cursor_direction_out <= 2'h0;
      cursor_addr_out <= 16'h0000;
    end else begin
      display_enable_out <= disp_en_q[`LCDC_DISP_EN_BIT];
      cursor_flash_rate_out <= disp_attr_q[1:0];
      screen_block_attribute_out <= disp_attr_q[7:2];
      cursor_width_out <= width_q[3:0];
      cursor_height_out <= hshape_q[3:0];
      cursor_shape_select_out <= hshape_q[`LCDC_SHAPE_BLOCK_BIT];
      cursor_direction_out <= dir_q[1:0];
      cursor_addr_out <= csr_q;
      case (reg_addr_in)
        `LCDC_REG_DISP_EN: reg_data_out <= disp_en_q;
        `LCDC_REG_DISP_ATTR: reg_data_out <= disp_attr_q;
        `LCDC_REG_CSR_WIDTH: reg_data_out <= width_q;
        `LCDC_REG_CSR_HSHAPE: reg_data_out <= hshape_q;
        `LCDC_REG_CURSOR_DIRECTION_CMD: reg_data_out <= dir_q;
        `LCDC_REG_CSR_LO: reg_data_out <= csr_q[7:0];
        `LCDC_REG_CSR_HI: reg_data_out <= csr_q[15:8];
        default: reg_data_out <= 8'h00;
      endcase
    end
  end

  lcdc_mem #(
    .AW(AW),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk_in(clk_in),
    .wr_en_in(mem_we),
    .wr_addr_in(csr_q[AW-1:0]),
    .wr_data_in(data_in),
    .rd_addr_in(mem_rd_addr_in),
    .rd_data_out(mem_rd_data_out)
  );
endmodule
`default_nettype wire

// File: verif/lcdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_host_model (
  // Clock
  input wire logic clk_in,
  // Byte stream
  output logic wr_out,
  output logic cmd_out,
  output logic [7:0] data_out
);
  initial begin
    wr_out = 1'b0;
    cmd_out = 1'b0;
    data_out = 8'h00;
  end
  // Bytes go back to back; once released, the bus shows inverted data.
  task automatic send(input logic [7:0] c, input logic [7:0] p[$]);
    @(negedge clk_in);
    wr_out = 1'b1;
    cmd_out = 1'b1;
    data_out = c;
    foreach (p[i]) begin
      @(negedge clk_in);
      cmd_out = 1'b0;
      data_out = p[i];
    end
    @(negedge clk_in);
    wr_out = 1'b0;
    data_out = ~data_out;
    @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// File: verif/lcdc_cmd_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_chk (
  // Clock, reset and stream
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic cmd_in,
  input wire logic [7:0] data_in,
  input wire logic [15:0] line_width_in,
  // Attribute outputs
  input wire logic display_enable_out,
  input wire logic [1:0] cursor_flash_rate_out,
  input wire logic [5:0] screen_block_attribute_out,
  input wire logic [3:0] cursor_width_out,
  input wire logic [3:0] cursor_height_out,
  input wire logic cursor_shape_select_out,
  input wire logic [1:0] cursor_direction_out,
  input wire logic [15:0] cursor_addr_out
);
  logic [7:0] lc_q;
  logic [1:0] pi_q;
  wire logic p0 = wr_in && !cmd_in && pi_q == 2'h0;
  wire logic p1 = wr_in && !cmd_in && pi_q == 2'h1;
  wire logic [3:0] lo = data_in[3:0];
  wire logic [4:0] hs = {data_in[7], data_in[3:0]};
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in) begin
    if (rst_in || (wr_in && cmd_in)) begin
      pi_q <= 2'h0;
    end else if (wr_in && pi_q != 2'h2) begin
      pi_q <= pi_q + 2'h1;
    end
    if (rst_in) begin
      lc_q <= 8'h00;
    end else if (wr_in && cmd_in) begin
      lc_q <= data_in;
    end
  end
  sequence s_lone_put;
    wr_in && !cmd_in && lc_q == 8'h42 ##1 !wr_in;
  endsequence
  a_disp_bit: assert property (wr_in && cmd_in && data_in[7:1] == 7'h2C
    |-> ##2 {3'h0, display_enable_out} == ($past(lo, 2) & 4'h1))
    else $error("display enable wrong");
  a_attr_byte: assert property (p0 && lc_q[7:1] == 7'h2C |-> ##2
    {screen_block_attribute_out, cursor_flash_rate_out} == $past(data_in, 2))
    else $error("attribute byte wrong");
  a_csr_low: assert property (p0 && lc_q == 8'h46 |-> ##2
    cursor_addr_out[7:0] == $past(data_in, 2)) else $error("cursor low wrong");
  a_csr_high: assert property (p1 && lc_q == 8'h46 |-> ##2
    cursor_addr_out[15:8] == $past(data_in, 2)) else $error("cursor high wrong");
  a_csr_width: assert property (p0 && lc_q == 8'h5D |-> ##2
    cursor_width_out == $past(lo, 2)) else $error("cursor width wrong");
  a_csr_shape: assert property (p1 && lc_q == 8'h5D |-> ##2
    {cursor_shape_select_out, cursor_height_out} == $past(hs, 2))
    else $error("cursor shape wrong");
  a_dir_code: assert property (wr_in && cmd_in && data_in[7:2] == 6'h13
    |-> ##2 {2'h0, cursor_direction_out} == ($past(lo, 2) & 4'h3))
    else $error("direction wrong");
  a_step_down: assert property (cursor_direction_out == 2'h3 ##0 s_lone_put
    |-> ##1 cursor_addr_out == $past(cursor_addr_out) + line_width_in)
    else $error("down step wrong");
endmodule
bind lcdc_cmd_decoder lcdc_chk i_lcdc_chk (.*);
`default_nettype wire

// File: verif/lcdc_cmd_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_cmd_decoder_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_in, cmd_in, display_enable_out, cursor_shape_select_out;
  logic [7:0] data_in, reg_data_out, mem_rd_data_out;
  logic [7:0] reg_addr_in = 8'h00;
  logic [14:0] mem_rd_addr_in = 15'h0000;
  logic [15:0] line_width_in = 16'h0080;
  logic [15:0] cursor_addr_out;
  logic [1:0] cursor_flash_rate_out, cursor_direction_out;
  logic [5:0] screen_block_attribute_out;
  logic [3:0] cursor_width_out, cursor_height_out;
  int bad_count = 0;
  int n_tests = 0;
  always #5 clk_in = ~clk_in;
  lcdc_host_model i_lcdc_host_model (.clk_in(clk_in), .wr_out(wr_in),
    .cmd_out(cmd_in), .data_out(data_in));
  lcdc_cmd_decoder i_lcdc_cmd_decoder (.*);
  task automatic chk(input string n, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic snd(input logic [7:0] c, input logic [7:0] p[$]);
    i_lcdc_host_model.send(c, p);
  endtask
  task automatic rd(input logic [7:0] a, e, input logic [14:0] m,
      input logic [7:0] f);
    @(negedge clk_in);
    reg_addr_in = a;
    mem_rd_addr_in = m;
    @(negedge clk_in);
    chk("register", e, reg_data_out);
    chk("memory", f, mem_rd_data_out);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    snd(8'h58, '{8'h56});
    chk("enable", 0, display_enable_out);
    chk("attr", 8'h56, {screen_block_attribute_out, cursor_flash_rate_out});
    $display("test off done");
    snd(8'h4C, '{8'h11});
    snd(8'h46, '{8'h00, 8'h00});
    snd(8'h42, '{8'h20, 8'h20, 8'h45});
    snd(8'h5D, '{8'h04, 8'h86});
    snd(8'h59, '{8'h56});
    chk("enable", 1, display_enable_out);
    chk("width", 4, cursor_width_out);
    chk("shape", 5'h16, {cursor_shape_select_out, cursor_height_out});
    chk("cursor", 16'h0003, cursor_addr_out);
    rd(8'h09, 8'h01, 15'h0001, 8'h20);
    rd(8'h0A, 8'h56, 15'h0002, 8'h45);
    rd(8'h15, 8'h04, 15'h0000, 8'h20);
    rd(8'h16, 8'h86, 15'h0000, 8'h20);
    $display("test store done");
    snd(8'h46, '{8'h01, 8'h10, 8'h77});
    chk("cursor", 16'h1001, cursor_addr_out);
    snd(8'h4F, '{8'h11});
    snd(8'h42, '{8'hFF, 8'hFF});
    chk("cursor", 16'h1101, cursor_addr_out);
    rd(8'h17, 8'h03, 15'h1001, 8'hFF);
    rd(8'h1C, 8'h01, 15'h1081, 8'hFF);
    rd(8'h1D, 8'h11, 15'h1081, 8'hFF);
    rd(8'h00, 8'h00, 15'h1001, 8'hFF);
    $display("test down done");
    for (int k = 0; k < 4; k++) begin
      snd(8'h4C + 8'(k), '{8'h11});
      chk("direction", 16'(k), cursor_direction_out);
    end
    $display("test dirs done");
    finish_test();
  end
endmodule
`default_nettype wire
